/* e3tx_bip8.sv */
// BIP-8 accumulator over every byte of a frame, result held for the next frame.
`timescale 1ns/1ps
`default_nettype none
module e3tx_bip8 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic frame_end,
  output logic [7:0] bip_q
);
  import e3tx_pkg::*;
  logic [7:0] acc_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_q <= 8'h00;
      bip_q <= 8'h00;
    end else if (byte_valid) begin
      if (frame_end) begin
        acc_q <= 8'h00;
        bip_q <= acc_q ^ byte_in;
      end else begin
        acc_q <= acc_q ^ byte_in;
      end
    end
  end

  bip_result_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_valid && frame_end |=> bip_q == ($past(acc_q) ^ $past(byte_in))) else $error("BIP result wrong.");
endmodule
`default_nettype wire

/* e3tx_line_rx.sv */
// Line-side receiver model: tracks frame position, captures overhead bytes and frame parity.
`timescale 1ns/1ps
`default_nettype none
module e3tx_line_rx (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] line_data_q,
  input wire logic line_valid_q,
  input wire logic frame_start_q,
  input wire logic hdlc_pull_q,
  output logic [7:0] fa1_q,
  output logic [7:0] fa2_q,
  output logic [7:0] em_q,
  output logic [7:0] ma_q,
  output logic [7:0] nr_q,
  output logic [7:0] gc_q,
  output logic [7:0] pbip_q,
  output logic [1:0] pulls_q,
  output logic [15:0] frames_q
);
  import e3tx_pkg::*;
  logic [9:0] pos_d;
  logic [9:0] pos_q;
  logic [7:0] bip_q;
  logic [1:0] pull_cnt_q;
  assign pos_d = frame_start_q ? POS_FA1 : pos_q + 10'h001;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos_q <= '0;
      frames_q <= '0;
    end else if (line_valid_q) begin
      pos_q <= pos_d;
      bip_q <= frame_start_q ? line_data_q : bip_q ^ line_data_q;
      if (frame_start_q) pbip_q <= bip_q;
      case (pos_d)
        POS_FA1: fa1_q <= line_data_q;
        POS_FA2: fa2_q <= line_data_q;
        POS_EM: em_q <= line_data_q;
        POS_MA: ma_q <= line_data_q;
        POS_NR: nr_q <= line_data_q;
        POS_GC: gc_q <= line_data_q;
        POS_GC + 10'h004: begin
          frames_q <= frames_q + 16'h0001;
          pulls_q <= pull_cnt_q;
        end
        default: ;
      endcase
    end
  end
  // Counts HDLC byte requests in each frame.
  always_ff @(posedge clk) begin
    if (!rst_b) pull_cnt_q <= '0;
    else if (line_valid_q && frame_start_q) pull_cnt_q <= {1'b0, hdlc_pull_q};
    else if (hdlc_pull_q) pull_cnt_q <= pull_cnt_q + 2'h1;
  end
endmodule
`default_nettype wire

/* e3tx_ohctl.sv */
// Transmit overhead controller top: registers, overhead build and error insertion.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module e3tx_ohctl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rd_data_q,
  input wire logic [7:0] pay_data,
  input wire logic pay_valid,
  input wire logic [7:0] hdlc_data,
  input wire logic [7:0] feac_data,
  output logic hdlc_pull_q,
  input wire logic ext_manual_err_in,
  input wire logic ext_remote_err_in,
  input wire logic rx_los,
  input wire logic rx_oof,
  input wire logic rx_ais,
  input wire logic rx_los_rdi_disable,
  input wire logic rx_oof_rdi_disable,
  input wire logic rx_ais_rdi_disable,
  output logic [7:0] line_data_q,
  output logic line_valid_q,
  output logic frame_start_q
);
  import e3tx_pkg::*;

  logic [15:0] tfc_q;
  logic [15:0] tei_q;
  logic [15:0] tma_q;
  logic [15:0] ngc_q;
  logic [9:0] pos_q;
  logic mf_q;
  logic [1:0] fe_burst_q;
  logic fe_word_q;
  logic [ERR_KINDS-1:0] pend_q;
  logic [ERR_KINDS-1:0] err_en;
  logic [ERR_KINDS-1:0] opp;
  logic trig;
  logic [7:0] bip;
  logic [2:0] alarm_s1_q;
  logic [2:0] alarm_s2_q;
  logic rei_s1_q;
  logic rei_s2_q;
  logic rei_seen_q;
  logic rdi_auto;
  logic tx_rdi;
  logic tx_rei;
  logic fe_fire;
  logic pe_fire;
  logic rei_fire;
  logic [2:0] tsi_field;
  logic [7:0] ma_byte;
  logic [7:0] nr_byte;
  logic [7:0] gc_byte;
  logic [7:0] tx_byte;
  logic [7:0] out_byte;
  logic hdlc_take;
  logic frame_end;
  e3tx_nr_src_type nr_src;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tfc_q <= REG_RESET;
    end else if (reg_wr_en && reg_addr == TX_FRAME_CONTROL_OFS) begin
      tfc_q <= reg_wr_data & TFC_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tei_q <= REG_RESET;
    end else if (reg_wr_en && reg_addr == TX_ERROR_INSERT_CONTROL_OFS) begin
      tei_q <= reg_wr_data & TEI_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tma_q <= REG_RESET;
    end else if (reg_wr_en && reg_addr == TX_MA_BYTE_FIELDS_OFS) begin
      tma_q <= reg_wr_data & TMA_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ngc_q <= REG_RESET;
    end else if (reg_wr_en && reg_addr == TX_NR_GC_BYTES_OFS) begin
      ngc_q <= reg_wr_data;
    end
  end

  // Read data appear in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rd_data_q <= REG_RESET;
    end else if (reg_rd_en) begin
      case (reg_addr)
        TX_FRAME_CONTROL_OFS: reg_rd_data_q <= tfc_q;
        TX_ERROR_INSERT_CONTROL_OFS: reg_rd_data_q <= tei_q;
        TX_MA_BYTE_FIELDS_OFS: reg_rd_data_q <= tma_q;
        TX_NR_GC_BYTES_OFS: reg_rd_data_q <= ngc_q;
        TX_STATUS_OFS: reg_rd_data_q <= {8'h00, tx_rdi, tx_rei, mf_q, fe_burst_q, pend_q};
        default: reg_rd_data_q <= 16'h0000;
      endcase
    end else begin
      reg_rd_data_q <= 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alarm_s1_q <= 3'h0;
      alarm_s2_q <= 3'h0;
      rei_s1_q <= 1'b0;
      rei_s2_q <= 1'b0;
    end else begin
      alarm_s1_q <= {rx_ais, rx_oof, rx_los};
      alarm_s2_q <= alarm_s1_q;
      rei_s1_q <= ext_remote_err_in;
      rei_s2_q <= rei_s1_q;
    end
  end

  assign frame_end = pos_q == POS_LAST;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos_q <= POS_FA1;
      mf_q <= 1'b0;
    end else if (pay_valid) begin
      pos_q <= frame_end ? POS_FA1 : pos_q + 10'h001;
      mf_q <= frame_end ? ~mf_q : mf_q;
    end
  end

  assign rdi_auto = (alarm_s2_q[0] & ~rx_los_rdi_disable) | (alarm_s2_q[1] & ~rx_oof_rdi_disable) |
                    (alarm_s2_q[2] & ~rx_ais_rdi_disable);
  assign tx_rdi = tfc_q[RDI_DEFEAT_BIT] ? tfc_q[MANUAL_RDI_BIT] : rdi_auto;

  // An error indication arriving as the MA byte leaves is kept for the next frame.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rei_seen_q <= 1'b0;
    end else if (rei_s2_q) begin
      rei_seen_q <= 1'b1;
    end else if (pay_valid && pos_q == POS_MA) begin
      rei_seen_q <= 1'b0;
    end
  end

  assign tx_rei = tfc_q[REI_DEFEAT_BIT] ? tfc_q[MANUAL_REI_BIT] : rei_seen_q;

  e3tx_trig u_trig (
    .clk(clk),
    .rst_b(rst_b),
    .ext_manual_err_in(ext_manual_err_in),
    .single_err_insert(tei_q[SINGLE_ERR_BIT]),
    .manual_trigger_select(tei_q[TRIG_SEL_BIT]),
    .trig_q(trig)
  );

  assign err_en = {tei_q[REI_EN_BIT], tei_q[PE_EN_BIT], tei_q[FE_EN_BIT]};
  assign opp = {pay_valid && pos_q == POS_MA, pay_valid && pos_q == POS_EM, pay_valid && pos_q == POS_FA1};

  genvar k;
  generate
    for (k = 0; k < ERR_KINDS; k = k + 1) begin : g_pend
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          pend_q[k] <= 1'b0;
        end else if (trig && err_en[k]) begin
          pend_q[k] <= 1'b1;
        end else if (opp[k] || !err_en[k]) begin
          pend_q[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // framing error one or four frames
  assign fe_fire = err_en[ERR_FE] && (pend_q[ERR_FE] || fe_burst_q != 2'h0);
  assign pe_fire = err_en[ERR_PE] && (pend_q[ERR_PE] || tei_q[PE_CONT_BIT]);
  assign rei_fire = err_en[ERR_REI] && (pend_q[ERR_REI] || tei_q[REI_CONT_BIT]);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fe_burst_q <= 2'h0;
      fe_word_q <= 1'b0;
    end else if (opp[ERR_FE]) begin
      fe_word_q <= fe_fire && tei_q[FE_TYPE_LSB];
      if (!err_en[ERR_FE]) begin
        fe_burst_q <= 2'h0;
      end else if (fe_burst_q != 2'h0) begin
        fe_burst_q <= fe_burst_q - 2'h1;
      end else if (pend_q[ERR_FE] && tei_q[FE_TYPE_LSB+1]) begin
        fe_burst_q <= FE_BURST_RELOAD;
      end
    end
  end

  assign tsi_field = tma_q[TSI_DIS_BIT] ? tma_q[TSI_LSB+2:TSI_LSB] :
                     {(mf_q ? tma_q[TSI_LSB+1:TSI_LSB] : tma_q[TSI_LSB+3:TSI_LSB+2]), ~mf_q};
  assign ma_byte = {tx_rdi, tx_rei ^ rei_fire, tma_q[PTYPE_LSB+2:PTYPE_LSB], tsi_field};

  assign nr_src = e3tx_nr_src_type'(tfc_q[NR_SEL_LSB+1:NR_SEL_LSB]);

  always_comb begin
    case (nr_src)
      NR_ONES: nr_byte = ALL_ONES;
      NR_HDLC: nr_byte = hdlc_data;
      NR_FEAC: nr_byte = feac_data;
      NR_REG: nr_byte = ngc_q[7:0];
      default: nr_byte = ALL_ONES;
    endcase
  end

  assign gc_byte = tfc_q[GC_SEL_BIT] ? ngc_q[15:8] : hdlc_data;

  assign hdlc_take = pay_valid && ((pos_q == POS_NR && nr_src == NR_HDLC) ||
                                   (pos_q == POS_GC && !tfc_q[GC_SEL_BIT]));

  always_comb begin
    tx_byte = pay_data;
    case (pos_q)
      POS_FA1: begin
        tx_byte = (tfc_q[FRAME_GEN_DIS_BIT] ? pay_data : FA1_WORD) ^
                  (fe_fire ? (tei_q[FE_TYPE_LSB] ? ALL_ONES : BIT_FLIP) : 8'h00);
      end
      POS_FA2: begin
        tx_byte = (tfc_q[FRAME_GEN_DIS_BIT] ? pay_data : FA2_WORD) ^ (fe_word_q ? ALL_ONES : 8'h00);
      end
      POS_EM: begin
        tx_byte = (tfc_q[FRAME_GEN_DIS_BIT] ? pay_data : bip) ^
                  (pe_fire ? (tei_q[PE_BLOCK_BIT] ? ALL_ONES : BIT_FLIP) : 8'h00);
      end
      POS_MA: tx_byte = ma_byte;
      POS_NR: tx_byte = nr_byte;
      POS_GC: tx_byte = gc_byte;
      default: tx_byte = pay_data;
    endcase
  end

  assign out_byte = tfc_q[FORCE_AIS_BIT] ? ALL_ONES : tx_byte;

  e3tx_bip8 u_bip (
    .clk(clk),
    .rst_b(rst_b),
    .byte_valid(pay_valid),
    .byte_in(tx_byte),
    .frame_end(frame_end),
    .bip_q(bip)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_data_q <= 8'h00;
      line_valid_q <= 1'b0;
      frame_start_q <= 1'b0;
      hdlc_pull_q <= 1'b0;
    end else begin
      line_data_q <= pay_valid ? out_byte : line_data_q;
      line_valid_q <= pay_valid;
      frame_start_q <= pay_valid && pos_q == POS_FA1;
      hdlc_pull_q <= hdlc_take;
    end
  end

  ais_ones_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && tfc_q[FORCE_AIS_BIT] |=> line_valid_q && line_data_q == 8'hff) else $error("AIS not all ones.");

  gc_register_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_GC && tfc_q[GC_SEL_BIT] && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q == $past(ngc_q[15:8])) else $error("GC byte not from register.");

  nr_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_NR && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q == ($past(tfc_q[9:8]) == 2'h0 ? 8'hff : $past(tfc_q[9:8]) == 2'h2 ? $past(feac_data) :
                        $past(tfc_q[9:8]) == 2'h3 ? $past(ngc_q[7:0]) : $past(hdlc_data)))
    else $error("NR byte source wrong.");

  hdlc_pull_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_GC && !tfc_q[GC_SEL_BIT] |=> hdlc_pull_q ##1 !hdlc_pull_q)
    else $error("HDLC pull missing.");

  ma_rdi_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_MA && tfc_q[RDI_DEFEAT_BIT] && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q[7] == $past(tfc_q[MANUAL_RDI_BIT])) else $error("Manual RDI not sent.");

  rdi_alarm_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_MA && !tfc_q[RDI_DEFEAT_BIT] && !tfc_q[FORCE_AIS_BIT]
    && alarm_s2_q[0] && !rx_los_rdi_disable |=> line_data_q[7]) else $error("LOS did not set RDI.");

  ma_ptype_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_MA && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q[5:3] == $past(tma_q[7:5])) else $error("Payload type misplaced.");

  parity_flip_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_EM && pe_fire && !tfc_q[FRAME_GEN_DIS_BIT] && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q == ($past(bip) ^ ($past(tei_q[PE_BLOCK_BIT]) ? 8'hff : 8'h01)))
    else $error("EM byte error wrong.");

  single_once_a: assert property (@(posedge clk) disable iff (!rst_b)
    opp[ERR_PE] && pend_q[ERR_PE] && !trig |=> !pend_q[ERR_PE]) else $error("Parity pending not consumed.");

  fe_burst_a: assert property (@(posedge clk) disable iff (!rst_b)
    opp[ERR_FE] && fe_fire && fe_burst_q == 2'h0 && tei_q[FE_TYPE_LSB+1] |=> fe_burst_q == FE_BURST_RELOAD)
    else $error("Four-frame burst not loaded.");

  gc_hdlc_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_GC && !tfc_q[GC_SEL_BIT] && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q == $past(hdlc_data)) else $error("GC byte not from HDLC.");

  ma_rei_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_MA && tfc_q[REI_DEFEAT_BIT] && !rei_fire && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q[6] == $past(tfc_q[MANUAL_REI_BIT])) else $error("Manual REI not sent.");

  frame_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_FA2 && tfc_q[FRAME_GEN_DIS_BIT] && !fe_word_q && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q == $past(pay_data)) else $error("FA2 not passed through.");

  rei_cont_a: assert property (@(posedge clk) disable iff (!rst_b)
    pay_valid && pos_q == POS_MA && tei_q[REI_EN_BIT] && tei_q[REI_CONT_BIT] && !tfc_q[FORCE_AIS_BIT]
    |=> line_data_q[6] != $past(tx_rei)) else $error("Continuous REI error missing.");

  pe_disable_a: assert property (@(posedge clk) disable iff (!rst_b)
    !tei_q[PE_EN_BIT] |=> !pend_q[ERR_PE])
    else $error("Parity pending while disabled.");

  read_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd_en && reg_addr == TX_ERROR_INSERT_CONTROL_OFS |=> reg_rd_data_q == $past(tei_q))
    else $error("Read data wrong.");
endmodule
`default_nettype wire

/* e3tx_ohctl_tb.sv */
// Self-checking bench for the transmit overhead controller.
`timescale 1ns/1ps
`default_nettype none
module e3tx_ohctl_tb;
  import e3tx_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [8:0] reg_addr = '0;
  logic [15:0] reg_wr_data = '0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_rd_data_q;
  logic [7:0] pay_data = 8'h00;
  logic pay_valid = 1'b0;
  logic [7:0] hdlc_data = 8'h3c;
  logic [7:0] feac_data = 8'hc3;
  logic hdlc_pull_q;
  logic ext_man = 1'b0;
  logic ext_rem = 1'b0;
  logic [2:0] alm = '0;
  logic [2:0] alm_dis = '0;
  logic [7:0] line_data_q;
  logic line_valid_q;
  logic frame_start_q;
  logic [7:0] fa1, fa2, em, ma, nr, gc, pbip, x;
  logic [1:0] pulls;
  logic [15:0] frames;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [8:0] adr [4] = '{TX_FRAME_CONTROL_OFS, TX_ERROR_INSERT_CONTROL_OFS,
    TX_MA_BYTE_FIELDS_OFS, TX_NR_GC_BYTES_OFS};
  logic [15:0] msk [4] = '{TFC_WMASK, TEI_WMASK, TMA_WMASK, 16'hffff};
  logic [15:0] tei_t [11] = '{16'h0004, 16'h000c, 16'h0014, 16'h001c, 16'h0020, 16'h00a0, 16'h0060,
    16'h0100, 16'h0300, 16'h0200, 16'h0005};
  int sel_t [11] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 0};
  int num_t [11] = '{1, 1, 4, 4, 1, 1, 4, 1, 4, 0, 1};
  logic [7:0] pat_t [11] = '{8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'h40, 8'h40, 8'h00, 8'h01};

  always #10 clk = ~clk;

  e3tx_ohctl e3tx_ohctl_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q), .pay_data(pay_data), .pay_valid(pay_valid),
    .hdlc_data(hdlc_data), .feac_data(feac_data), .hdlc_pull_q(hdlc_pull_q), .ext_manual_err_in(ext_man),
    .ext_remote_err_in(ext_rem), .rx_los(alm[0]), .rx_oof(alm[1]), .rx_ais(alm[2]),
    .rx_los_rdi_disable(alm_dis[0]), .rx_oof_rdi_disable(alm_dis[1]), .rx_ais_rdi_disable(alm_dis[2]),
    .line_data_q(line_data_q), .line_valid_q(line_valid_q), .frame_start_q(frame_start_q));

  e3tx_line_rx e3tx_line_rx_inst (
    .clk(clk), .rst_b(rst_b), .line_data_q(line_data_q), .line_valid_q(line_valid_q),
    .frame_start_q(frame_start_q), .hdlc_pull_q(hdlc_pull_q), .fa1_q(fa1), .fa2_q(fa2), .em_q(em),
    .ma_q(ma), .nr_q(nr), .gc_q(gc), .pbip_q(pbip), .pulls_q(pulls), .frames_q(frames));

  task automatic test_done();
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(posedge clk);
    chk16("register", e, reg_rd_data_q);
  endtask

  task automatic frm(input int k);
    logic [15:0] f0;
    f0 = frames;
    while (frames !== f0 + 16'(k)) @(posedge clk);
  endtask

  // Error-free value of each watched byte is zero after this mapping.
  function automatic logic [7:0] pick(input int s);
    return (s == 0) ? fa1 ^ FA1_WORD : (s == 1) ? em ^ pbip : ma;
  endfunction

  task automatic watch(input int s, output int cnt, output logic [7:0] pat);
    cnt = 0;
    pat = 8'h00;
    repeat (s == 0 ? 5 : 4) begin
      frm(1);
      if (pick(s) !== 8'h00) begin
        if (cnt == 0) pat = pick(s);
        cnt++;
      end
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    pay_valid <= 1'b1;
    rd(TX_STATUS_OFS, REG_RESET);
    for (int i = 0; i < 4; i++) rd(adr[i], REG_RESET);
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 16'hffff);
      rd(adr[i], msk[i]);
      wr(adr[i], REG_RESET);
    end
    wr(9'h100, 16'hffff);
    rd(9'h100, 16'h0000);
    frm(2);
    chk8("fa1", FA1_WORD, fa1);
    chk8("nr", ALL_ONES, nr);
    wr(TX_NR_GC_BYTES_OFS, 16'h8142);
    for (int s = 0; s < 4; s++) begin
      wr(TX_FRAME_CONTROL_OFS, {5'h00, s[1], s[1:0], 8'h00});
      frm(2);
      chk8("nr", s == 0 ? ALL_ONES : s == 1 ? hdlc_data : s == 2 ? feac_data : 8'h42, nr);
      chk8("gc", s[1] ? 8'h81 : hdlc_data, gc);
      chk8("pulls", s == 1 ? 8'h02 : s[1] ? 8'h00 : 8'h01, {6'h00, pulls});
    end
    wr(TX_MA_BYTE_FIELDS_OFS, 16'h00bb);
    wr(TX_FRAME_CONTROL_OFS, 16'h001c);
    frm(2);
    chk8("ma", 8'hab, ma);
    wr(TX_FRAME_CONTROL_OFS, 16'h0034);
    frm(2);
    chk8("ma", 8'h6b, ma);
    wr(TX_MA_BYTE_FIELDS_OFS, 16'h00ab);
    frm(2);
    x = ma;
    frm(1);
    chk8("timing", 8'h2e, x[2:0] < ma[2:0] ? {2'b00, x[2:0], ma[2:0]} : {2'b00, ma[2:0], x[2:0]});
    wr(TX_FRAME_CONTROL_OFS, REG_RESET);
    wr(TX_MA_BYTE_FIELDS_OFS, 16'h0010);
    for (int k = 0; k < 3; k++) begin
      alm[k] <= 1'b1;
      frm(2);
      chk8("auto rdi", 8'h80, ma & 8'h80);
      alm_dis[k] <= 1'b1;
      frm(2);
      chk8("masked rdi", 8'h00, ma & 8'h80);
      alm[k] <= 1'b0;
      alm_dis[k] <= 1'b0;
    end
    ext_rem <= 1'b1;
    frm(2);
    chk8("auto rei", 8'h40, ma & 8'h40);
    ext_rem <= 1'b0;
    frm(2);
    chk8("auto rei", 8'h00, ma & 8'h40);
    pay_data <= 8'h5a;
    wr(TX_FRAME_CONTROL_OFS, 16'h0002);
    frm(2);
    chk8("fa1", 8'h5a, fa1);
    chk8("fa2", 8'h5a, fa2);
    wr(TX_FRAME_CONTROL_OFS, 16'h0001);
    frm(2);
    chk8("ais ma", ALL_ONES, ma);
    chk8("ais fa1", ALL_ONES, fa1);
    wr(TX_FRAME_CONTROL_OFS, REG_RESET);
    for (int c = 0; c < 11; c++) begin
      // both triggers stay low whenever the trigger source changes.
      wr(TX_ERROR_INSERT_CONTROL_OFS, REG_RESET);
      frm(1);
      wr(TX_ERROR_INSERT_CONTROL_OFS, tei_t[c]);
      frm(1);
      if (tei_t[c][0]) begin
        ext_man <= 1'b1;
        repeat (4) @(posedge clk);
        ext_man <= 1'b0;
      end else begin
        repeat (2) begin
          wr(TX_ERROR_INSERT_CONTROL_OFS, tei_t[c] | 16'h0002);
          wr(TX_ERROR_INSERT_CONTROL_OFS, tei_t[c]);
        end
      end
      watch(sel_t[c], n, x);
      chk8("error count", 8'(num_t[c]), 8'(n));
      chk8("error pattern", pat_t[c], x);
    end
    test_done();
  end
endmodule
`default_nettype wire

/* e3tx_pkg.sv */
// Constants, field positions and enumerations for the transmit overhead controller.
package e3tx_pkg;
  localparam logic [8:0] TX_FRAME_CONTROL_OFS = 9'h118;
  localparam logic [8:0] TX_ERROR_INSERT_CONTROL_OFS = 9'h11a;
  localparam logic [8:0] TX_MA_BYTE_FIELDS_OFS = 9'h11c;
  localparam logic [8:0] TX_NR_GC_BYTES_OFS = 9'h11e;
  localparam logic [8:0] TX_STATUS_OFS = 9'h110;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] TFC_WMASK = 16'h073f;
  localparam logic [15:0] TEI_WMASK = 16'h03ff;
  localparam logic [15:0] TMA_WMASK = 16'h00ff;
  localparam int FORCE_AIS_BIT = 0;
  localparam int FRAME_GEN_DIS_BIT = 1;
  localparam int RDI_DEFEAT_BIT = 2;
  localparam int MANUAL_RDI_BIT = 3;
  localparam int REI_DEFEAT_BIT = 4;
  localparam int MANUAL_REI_BIT = 5;
  localparam int NR_SEL_LSB = 8;
  localparam int GC_SEL_BIT = 10;
  localparam int TRIG_SEL_BIT = 0;
  localparam int SINGLE_ERR_BIT = 1;
  localparam int FE_EN_BIT = 2;
  localparam int FE_TYPE_LSB = 3;
  localparam int PE_EN_BIT = 5;
  localparam int PE_CONT_BIT = 6;
  localparam int PE_BLOCK_BIT = 7;
  localparam int REI_EN_BIT = 8;
  localparam int REI_CONT_BIT = 9;
  localparam int TSI_LSB = 0;
  localparam int TSI_DIS_BIT = 4;
  localparam int PTYPE_LSB = 5;
  localparam int ERR_KINDS = 3;
  localparam int ERR_FE = 0;
  localparam int ERR_PE = 1;
  localparam int ERR_REI = 2;
  localparam logic [9:0] POS_LAST = 10'h218;
  localparam logic [9:0] POS_FA1 = 10'h000;
  localparam logic [9:0] POS_FA2 = 10'h001;
  localparam logic [9:0] POS_EM = 10'h03c;
  localparam logic [9:0] POS_TR = 10'h077;
  localparam logic [9:0] POS_MA = 10'h0b2;
  localparam logic [9:0] POS_NR = 10'h0ed;
  localparam logic [9:0] POS_GC = 10'h128;
  localparam logic [7:0] FA1_WORD = 8'hf6;
  localparam logic [7:0] FA2_WORD = 8'h28;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] BIT_FLIP = 8'h01;
  localparam logic [1:0] FE_BURST_RELOAD = 2'h3;
  typedef enum logic [1:0] {NR_ONES, NR_HDLC, NR_FEAC, NR_REG} e3tx_nr_src_type;
endpackage

/* e3tx_trig.sv */
// Error trigger source: pin synchroniser, source select and rising-edge detect.
`timescale 1ns/1ps
`default_nettype none
module e3tx_trig (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_manual_err_in,
  input wire logic single_err_insert,
  input wire logic manual_trigger_select,
  output logic trig_q
);
  import e3tx_pkg::*;
  logic ext_s1_q;
  logic ext_s2_q;
  logic level_prev_q;
  logic level;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_manual_err_in;
      ext_s2_q <= ext_s1_q;
    end
  end

  assign level = manual_trigger_select ? ext_s2_q : single_err_insert;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_prev_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      level_prev_q <= level;
      trig_q <= level & ~level_prev_q;
    end
  end

  trig_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
    trig_q |-> $past(level) && !$past(level_prev_q)) else $error("Trigger without a rising edge.");
endmodule
`default_nettype wire
